// File: design/xaw_alu_top.sv
// apb-mapped xor and word add/subtract/compare slice with flag register
// assumes an apb master on pclk; no other clock, no interrupt
`timescale 1ns/1ns
`default_nettype none

module xaw_alu_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             op_done,
  output logic      [7:0]  psw_flags
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  xaw_pkg::xaw_state_t state_reg;
  xaw_pkg::xaw_state_t state_next;
  xaw_pkg::xaw_op_t    op_reg;
  xaw_pkg::xaw_op_t    op_next;
  logic [15:0]         dst_reg;
  logic [15:0]         dst_next;
  logic [15:0]         src_reg;
  logic [15:0]         src_next;
  logic [7:0]          flags_reg;
  logic [7:0]          flags_next;
  logic [7:0]          ptrext_reg;
  logic [7:0]          ptrext_next;
  logic [15:0]         opcnt_reg;
  logic [15:0]         opcnt_next;
  logic [15:0]         result_reg;
  logic [15:0]         result_next;
  logic [7:0]          calc_flags_reg;
  logic [7:0]          calc_flags_next;
  logic                wb_reg;
  logic                wb_next;
  logic                wrote_reg;
  logic                wrote_next;
  logic                done_reg;
  logic                done_next;
  logic [31:0]         prdata_reg;
  logic [31:0]         prdata_next;

  logic                access;
  logic                wr_take;
  logic                rd_mapped;
  logic                wr_mapped;
  logic                hit_cmd;
  logic                hit_dst;
  logic                hit_src;
  logic                hit_flags;
  logic                hit_ptrext;

  xaw_alu_if alu_bus ();

  // -----------------------------------------------------------------
  // register map and operation timing
  // -----------------------------------------------------------------
  // 0x00 opcode: a lane 0 write starts an operation, read gives the last
  // 0x04 destination word, read and write
  // 0x08 source word, read and write
  // 0x0c flags, writes masked to the five live bits
  // 0x10 status, read only: bit 0 busy, bit 1 last op wrote back
  // 0x14 pointer extension byte, untouched by every operation
  // 0x18 completed operation count, read only, wraps
  // 0x1c last core result, read only, kept for compare too
  // anything else reads zero and raises pslverr
  // writes to read-only words are ignored and raise pslverr
  // 16-bit words sit in bits 15:0; the upper half reads zero
  //
  // an opcode taken at edge e gives exec after e, commit after e+1,
  // the write-back at e+2 and the done pulse from e+2 to e+3;
  // pready is low for those two cycles, so a second opcode simply
  // waits in its access phase rather than being refused
  //
  // the pointer extension is software's to keep in step: a word
  // carry only ever reaches the carry and p/v flags, never that byte

  // -----------------------------------------------------------------
  // byte-lane merge for writable registers
  // -----------------------------------------------------------------
  // lanes beyond a register's width are simply ignored
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    logic [15:0] m;
    m = old;
    if (st[0]) begin
      m[7:0] = wd[7:0];
    end
    if (st[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  // every mapped word is readable; only five take writes
  // plain compare chain; the map is small, so depth is no concern
  always_comb begin
    hit_cmd    = 1'b0;
    hit_dst    = 1'b0;
    hit_src    = 1'b0;
    hit_flags  = 1'b0;
    hit_ptrext = 1'b0;
    rd_mapped  = 1'b1;
    if (paddr == xaw_pkg::ADDR_CMD) begin
      hit_cmd = 1'b1;
    end else if (paddr == xaw_pkg::ADDR_DST) begin
      hit_dst = 1'b1;
    end else if (paddr == xaw_pkg::ADDR_SRC) begin
      hit_src = 1'b1;
    end else if (paddr == xaw_pkg::ADDR_FLAGS) begin
      hit_flags = 1'b1;
    end else if (paddr == xaw_pkg::ADDR_PTREXT) begin
      hit_ptrext = 1'b1;
    end else if (paddr == xaw_pkg::ADDR_STATUS) begin
      rd_mapped = 1'b1;
    end else if (paddr == xaw_pkg::ADDR_OPCNT) begin
      rd_mapped = 1'b1;
    end else if (paddr == xaw_pkg::ADDR_RESULT) begin
      rd_mapped = 1'b1;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  assign wr_mapped = hit_cmd | hit_dst | hit_src | hit_flags | hit_ptrext;

  // -----------------------------------------------------------------
  // apb handshake
  // -----------------------------------------------------------------
  // stall every access while an operation is in flight, so software
  // never sees or overwrites operands halfway through a commit
  // zero wait states whenever the sequencer is idle
  assign pready  = (state_reg == xaw_pkg::ST_IDLE);
  assign access  = psel & penable & pready;
  assign wr_take = access & pwrite;
  // unmapped reads and writes to read-only words report an error
  // the error only counts with the access that pready completes
  assign pslverr = access & (pwrite ? ~wr_mapped : ~rd_mapped);

  // -----------------------------------------------------------------
  // operation sequencer
  // -----------------------------------------------------------------
  // idle -> exec (core result registered) -> commit (write back)
  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    done_next  = 1'b0;
    case (state_reg)
      xaw_pkg::ST_IDLE: begin
        // opcode without lane 0 is dropped, and no error is raised
        if (wr_take && hit_cmd && pstrb[0]) begin
          op_next    = xaw_pkg::xaw_op_t'(pwdata[1:0]);
          state_next = xaw_pkg::ST_EXEC;
        end
      end
      xaw_pkg::ST_EXEC: begin
        state_next = xaw_pkg::ST_COMMIT;
      end
      xaw_pkg::ST_COMMIT: begin
        done_next  = 1'b1;
        state_next = xaw_pkg::ST_IDLE;
      end
      default: begin
        state_next = xaw_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= xaw_pkg::ST_IDLE;
      op_reg    <= xaw_pkg::OP_XOR;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      done_reg  <= done_next;
    end
  end

  // -----------------------------------------------------------------
  // arithmetic core
  // -----------------------------------------------------------------
  // operands come straight from the held registers
  assign alu_bus.op       = op_reg;
  assign alu_bus.dst      = dst_reg;
  assign alu_bus.src      = src_reg;
  assign alu_bus.flags_in = flags_reg;

  xaw_alu_calc u_calc (
    .alu (alu_bus.calc)
  );

  // -----------------------------------------------------------------
  // core result capture
  // -----------------------------------------------------------------
  // registering here breaks the adder path away from the write-back
  always_comb begin
    result_next     = result_reg;
    calc_flags_next = calc_flags_reg;
    wb_next         = wb_reg;
    // only exec loads, so the result stays readable until the next op
    if (state_reg == xaw_pkg::ST_EXEC) begin
      result_next     = alu_bus.result;
      calc_flags_next = alu_bus.flags_out;
      wb_next         = alu_bus.writeback;
    end
  end

  // captured core outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg     <= xaw_pkg::DST_RST;
      calc_flags_reg <= xaw_pkg::FLAGS_RST;
      wb_reg         <= 1'b0;
    end else begin
      result_reg     <= result_next;
      calc_flags_reg <= calc_flags_next;
      wb_reg         <= wb_next;
    end
  end

  // -----------------------------------------------------------------
  // operand and flag registers
  // -----------------------------------------------------------------
  // software writes only land in idle, so they never race a commit;
  // the pointer extension is never touched by any operation
  always_comb begin
    dst_next    = dst_reg;
    src_next    = src_reg;
    flags_next  = flags_reg;
    ptrext_next = ptrext_reg;
    wrote_next  = wrote_reg;
    opcnt_next  = opcnt_reg;
    if (state_reg == xaw_pkg::ST_COMMIT) begin
      // compare updates flags and count just like the other ops
      flags_next = calc_flags_reg;
      // counter wraps silently; software reads it as a running total
      opcnt_next = opcnt_reg + 16'h0001;
      wrote_next = wb_reg;
      if (wb_reg) begin
        dst_next = result_reg;
      end
      // compare leaves dst_next at its old value
    end else if (wr_take) begin
      if (hit_dst) begin
        dst_next = merge16(dst_reg, pwdata, pstrb);
      end
      if (hit_src) begin
        src_next = merge16(src_reg, pwdata, pstrb);
      end
      if (hit_flags && pstrb[0]) begin
        flags_next = pwdata[7:0] & xaw_pkg::FLAGS_MASK;
      end
      if (hit_ptrext && pstrb[0]) begin
        ptrext_next = pwdata[7:0];
      end
    end
  end

  // operand, flag and bookkeeping registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_reg    <= xaw_pkg::DST_RST;
      src_reg    <= xaw_pkg::SRC_RST;
      flags_reg  <= xaw_pkg::FLAGS_RST;
      ptrext_reg <= xaw_pkg::PTREXT_RST;
      wrote_reg  <= 1'b0;
      opcnt_reg  <= xaw_pkg::OPCNT_RST;
    end else begin
      dst_reg    <= dst_next;
      src_reg    <= src_next;
      flags_reg  <= flags_next;
      ptrext_reg <= ptrext_next;
      wrote_reg  <= wrote_next;
      opcnt_reg  <= opcnt_next;
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  // mux over next values so the word captured at an edge matches the
  // register contents after that same edge; held when not selected
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !pwrite) begin
      if (paddr == xaw_pkg::ADDR_CMD) begin
        prdata_next = {30'h00000000, op_next};
      end else if (paddr == xaw_pkg::ADDR_DST) begin
        prdata_next = {16'h0000, dst_next};
      end else if (paddr == xaw_pkg::ADDR_SRC) begin
        prdata_next = {16'h0000, src_next};
      end else if (paddr == xaw_pkg::ADDR_FLAGS) begin
        prdata_next = {24'h000000, flags_next};
      end else if (paddr == xaw_pkg::ADDR_STATUS) begin
        prdata_next = {30'h00000000, wrote_next,
                       (state_next != xaw_pkg::ST_IDLE)};
      end else if (paddr == xaw_pkg::ADDR_PTREXT) begin
        prdata_next = {24'h000000, ptrext_next};
      end else if (paddr == xaw_pkg::ADDR_OPCNT) begin
        prdata_next = {16'h0000, opcnt_next};
      end else if (paddr == xaw_pkg::ADDR_RESULT) begin
        prdata_next = {16'h0000, result_next};
      end else begin
        // unmapped reads give zero so stale data never leaks out
        prdata_next = 32'h00000000;
      end
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // every data output is a flop, so the core side sees no glitch
  // while the adder settles
  assign prdata    = prdata_reg;
  assign op_done   = done_reg;   // one cycle after the commit edge
  assign psw_flags = flags_reg;

endmodule

`default_nettype wire

// File: design/xaw_pkg.sv
// constants, types and register map of the xor / word add-subtract slice
// assumes a single pclk domain and an apb master in front of the slice

`default_nettype none

package xaw_pkg;

  // -----------------------------------------------------------------
  // bus and operand widths
  // -----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;

  // -----------------------------------------------------------------
  // register byte addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_DST    = 8'h04;
  localparam logic [7:0] ADDR_SRC    = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_PTREXT = 8'h14;
  localparam logic [7:0] ADDR_OPCNT  = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1c;

  // -----------------------------------------------------------------
  // flag positions in the program status byte
  // -----------------------------------------------------------------
  localparam int unsigned FLAG_S_BIT  = 7;
  localparam int unsigned FLAG_Z_BIT  = 6;
  localparam int unsigned FLAG_AC_BIT = 4;
  localparam int unsigned FLAG_PV_BIT = 2;
  localparam int unsigned FLAG_CY_BIT = 0;
  localparam logic [7:0]  FLAGS_MASK  = 8'hd5;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [15:0] DST_RST    = 16'h0000;
  localparam logic [15:0] SRC_RST    = 16'h0000;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  PTREXT_RST = 8'h00;
  localparam logic [15:0] OPCNT_RST  = 16'h0000;

  // -----------------------------------------------------------------
  // operations and sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_XOR = 2'b00,
    OP_ADD = 2'b01,
    OP_SUB = 2'b10,
    OP_CMP = 2'b11
  } xaw_op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_COMMIT = 2'b11
  } xaw_state_t;

endpackage

`default_nettype wire

// File: design/xaw_alu_if.sv
// operand and result bundle between sequencer and arithmetic core
// assumes both ends sit on the same pclk domain
`timescale 1ns/1ns
`default_nettype none

interface xaw_alu_if;
  xaw_pkg::xaw_op_t op;
  logic [15:0]      dst;
  logic [15:0]      src;
  logic [7:0]       flags_in;
  logic [15:0]      result;
  logic [7:0]       flags_out;
  logic             writeback;

  // sequencer drives operands, core answers combinationally
  modport core (output op, output dst, output src, output flags_in,
                input result, input flags_out, input writeback);
  modport calc (input op, input dst, input src, input flags_in,
                output result, output flags_out, output writeback);
endinterface

`default_nettype wire

// File: design/xaw_alu_calc.sv
// combinational arithmetic core: byte xor and word add, subtract, compare
// assumes operands held stable by the sequencer for a full cycle
`timescale 1ns/1ns
`default_nettype none

module xaw_alu_calc (
  xaw_alu_if.calc alu
);

  // -----------------------------------------------------------------
  // result and flag evaluation
  // -----------------------------------------------------------------
  // one 17-bit adder path per kind; bit 16 is carry or borrow out
  always_comb begin
    logic [16:0] wide;
    logic        c_in15;
    logic [7:0]  f;
    wide   = 17'h00000;
    c_in15 = 1'b0;
    f      = alu.flags_in;
    case (alu.op)
      xaw_pkg::OP_XOR: begin
        // all-ones source falls out as plain inversion
        wide[15:0] = {alu.dst[15:8], alu.dst[7:0] ^ alu.src[7:0]};
        f[xaw_pkg::FLAG_S_BIT]  = wide[7];
        f[xaw_pkg::FLAG_Z_BIT]  = (wide[7:0] == 8'h00);
        f[xaw_pkg::FLAG_PV_BIT] = ~^wide[7:0];
        // aux carry and carry pass through from flags_in
      end
      xaw_pkg::OP_ADD: begin
        wide   = {1'b0, alu.dst} + {1'b0, alu.src};
        c_in15 = alu.dst[15] ^ alu.src[15] ^ wide[15];
        f[xaw_pkg::FLAG_S_BIT]  = wide[15];
        f[xaw_pkg::FLAG_Z_BIT]  = (wide[15:0] == 16'h0000);
        f[xaw_pkg::FLAG_PV_BIT] = c_in15 ^ wide[16];
        f[xaw_pkg::FLAG_CY_BIT] = wide[16];
      end
      default: begin
        // subtract and compare share the path; only writeback differs
        wide   = {1'b0, alu.dst} - {1'b0, alu.src};
        c_in15 = alu.dst[15] ^ alu.src[15] ^ wide[15];
        f[xaw_pkg::FLAG_S_BIT]  = wide[15];
        f[xaw_pkg::FLAG_Z_BIT]  = (wide[15:0] == 16'h0000);
        f[xaw_pkg::FLAG_PV_BIT] = c_in15 ^ wide[16];
        f[xaw_pkg::FLAG_CY_BIT] = wide[16];
      end
    endcase
    // word ops keep the old aux carry, one legal undefined value
    alu.result    = wide[15:0];
    alu.flags_out = f & xaw_pkg::FLAGS_MASK;
    alu.writeback = (alu.op != xaw_pkg::OP_CMP);
  end

endmodule

`default_nettype wire

// File: dv/xaw_alu_props.sv
// port-level checks of the xor / word add-subtract slice
// assumes one pclk domain; bound to xaw_alu_top after the module
`timescale 1ns/1ns
`default_nettype none

module xaw_alu_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        op_done,
  input wire logic [7:0]  psw_flags
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic             take;
  logic             cmd_take;
  logic             flag_wr;
  xaw_pkg::xaw_op_t op_reg;
  xaw_pkg::xaw_op_t op_next;

  // accepted transfers; cmd needs lane 0 or it is ignored
  assign take     = psel && penable && pready;
  assign cmd_take = take && pwrite && paddr == xaw_pkg::ADDR_CMD && pstrb[0];
  assign flag_wr  = take && pwrite && paddr == xaw_pkg::ADDR_FLAGS;

  // opcode of the operation in flight
  always_comb begin
    op_next = op_reg;
    if (cmd_take) begin
      op_next = xaw_pkg::xaw_op_t'(pwdata[1:0]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg <= xaw_pkg::OP_XOR;
    end else begin
      op_reg <= op_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // assertions; flag bits: 7 sign, 6 zero, 4 aux, 2 p/v, 0 carry
  // ---------------------------------------------------------------
  op_seq_a: assert property (cmd_take |=> !pready [*2] ##1 (pready && op_done))
    else $error("operation handshake out of step");
  done_cause_a: assert property (op_done |-> $past(cmd_take, 3) && !$past(op_done))
    else $error("done pulse without a command");
  flags_cause_a: assert property ($changed(psw_flags) |-> op_done || $past(flag_wr))
    else $error("flags moved without cause");
  xor_carry_a: assert property (cmd_take && pwdata[1:0] == 2'b00
      |-> ##3 psw_flags[0] == $past(psw_flags[0], 3))
    else $error("xor changed carry");
  aux_keep_a: assert property (cmd_take |-> ##3 psw_flags[4] == $past(psw_flags[4], 3))
    else $error("aux carry changed by an operation");
  zero_sign_a: assert property (op_done && psw_flags[6] |-> !psw_flags[7])
    else $error("zero result with sign set");
  xor_parity_a: assert property (op_done && op_reg == xaw_pkg::OP_XOR && psw_flags[6] |-> psw_flags[2])
    else $error("zero xor result without even parity");
  sub_zero_a: assert property (op_done && op_reg[1] && psw_flags[6]
      |-> !psw_flags[0] && !psw_flags[2])
    else $error("equal operands gave borrow or overflow");
  unmapped_err_a: assert property (take && paddr > xaw_pkg::ADDR_RESULT |-> pslverr)
    else $error("unmapped access without error");

  cover property (op_done && op_reg == xaw_pkg::OP_XOR);
  cover property (op_done && op_reg == xaw_pkg::OP_ADD && psw_flags[0]);
  cover property (op_done && op_reg == xaw_pkg::OP_CMP && psw_flags[6]);
endmodule

bind xaw_alu_top xaw_alu_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .op_done(op_done), .psw_flags(psw_flags));

`default_nettype wire

// File: dv/xor_and_word_add_sub_alu_tb.sv
// self-checking bench of the xor / word add-subtract slice
// assumes xaw_pkg and xaw_alu_top compiled first; the apb master lives here
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module xor_and_word_add_sub_alu_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, op_done, err;
  logic [7:0]  paddr, psw_flags;
  logic [3:0]  pstrb, strb;
  logic [31:0] pwdata, prdata, rd, rv, rw;
  logic [41:0] corner [10];
  int          n_mismatch, samples_checked, seed, nops;

  xaw_alu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_done(op_done), .psw_flags(psw_flags));

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // apb master and expectation model
  // ---------------------------------------------------------------
  // request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // returns {flags, core result, new destination}
  function automatic logic [39:0] model(input logic [1:0] op, input logic [15:0] d, input logic [15:0] s,
                                        input logic [7:0] f);
    logic [16:0] r;
    logic [15:0] t;
    logic [7:0]  nf;
    nf = f;
    r = op == 2'd0 ? {1'b0, d[15:8], d[7:0] ^ s[7:0]} : op == 2'd1 ? {1'b0, d} + {1'b0, s} : {1'b0, d} - {1'b0, s};
    t = op == 2'd1 ? {1'b0, d[14:0]} + {1'b0, s[14:0]} : {1'b0, d[14:0]} - {1'b0, s[14:0]};
    if (op == 2'd0) begin
      nf[7] = r[7];
      nf[6] = r[7:0] == 8'h00;
      nf[2] = ~^r[7:0];
    end else begin
      nf[7] = r[15];
      nf[6] = r[15:0] == 16'h0000;
      nf[2] = t[15] ^ r[16];
      nf[0] = r[16];
    end
    return {nf, r[15:0], op == 2'd3 ? d : r[15:0]};
  endfunction

  // load operands and flags, start, wait for done, compare
  task automatic run_op(input logic [1:0] op, input logic [15:0] d, input logic [15:0] s, input logic [7:0] f);
    logic [39:0] e;
    int          n;
    e = model(op, d, s, f & 8'hd5);
    xfer(1'b1, xaw_pkg::ADDR_FLAGS, {24'h0, f});
    xfer(1'b1, xaw_pkg::ADDR_DST, {16'h0, d});
    xfer(1'b1, xaw_pkg::ADDR_SRC, {16'h0, s});
    xfer(1'b1, xaw_pkg::ADDR_CMD, {30'h0, op});
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (op_done !== 1'b1 && n < 8);
    `CHK("done latency", 3, n)
    case (op)
      2'd0: `CHK("xor flags", e[39:32], psw_flags)
      2'd1: `CHK("add flags", e[39:32], psw_flags)
      2'd2: `CHK("sub flags", e[39:32], psw_flags)
      default: `CHK("cmp flags", e[39:32], psw_flags)
    endcase
    xfer(1'b0, xaw_pkg::ADDR_DST, 32'h0);
    case (op)
      2'd0: `CHK("xor dst", {16'h0, e[15:0]}, rd)
      2'd1: `CHK("add dst", {16'h0, e[15:0]}, rd)
      2'd2: `CHK("sub dst", {16'h0, e[15:0]}, rd)
      default: `CHK("cmp dst", {16'h0, e[15:0]}, rd)
    endcase
    xfer(1'b0, xaw_pkg::ADDR_STATUS, 32'h0);
    `CHK("status", {30'h0, op != 2'd3, 1'b0}, rd)
    xfer(1'b0, xaw_pkg::ADDR_CMD, 32'h0);
    `CHK("opcode", {30'h0, op}, rd)
    if (op[1]) begin
      xfer(1'b0, xaw_pkg::ADDR_RESULT, 32'h0);
      `CHK("difference", e[31:16], rd[15:0])
    end
    nops++;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  // corners: {op, dst, src, flags}; all-ones xor, zero, overflow, carry, borrow
  initial begin
    corner = '{{2'd0, 16'h1234, 16'h00ff, 8'h11}, {2'd0, 16'hab5a, 16'h005a, 8'hd5},
               {2'd1, 16'h7fff, 16'h0001, 8'h00}, {2'd1, 16'h8000, 16'h8000, 8'h10},
               {2'd1, 16'hffff, 16'h0001, 8'h00}, {2'd2, 16'h1234, 16'h1234, 8'h01},
               {2'd2, 16'h0000, 16'h0001, 8'h00}, {2'd2, 16'h8000, 16'h0001, 8'h00},
               {2'd3, 16'h5555, 16'h5555, 8'h01}, {2'd3, 16'h7fff, 16'hffff, 8'h00}};
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    strb = 4'hf;
    presetn = 1'b0;
    seed = 76;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 7; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    $display("test reset done");
    xfer(1'b1, xaw_pkg::ADDR_PTREXT, 32'ha5);
    xfer(1'b0, 8'h20, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    xfer(1'b1, xaw_pkg::ADDR_STATUS, 32'hff);
    `CHK("read-only error", 1'b1, err)
    // upper lane only, then an opcode without lane 0 that must be dropped
    strb = 4'h2;
    xfer(1'b1, xaw_pkg::ADDR_DST, 32'h1234);
    strb = 4'h0;
    xfer(1'b1, xaw_pkg::ADDR_CMD, 32'h1);
    strb = 4'hf;
    `CHK("lane 0 off error", 1'b0, err)
    xfer(1'b0, xaw_pkg::ADDR_DST, 32'h0);
    `CHK("lane merge", 32'h1200, rd)
    xfer(1'b0, xaw_pkg::ADDR_STATUS, 32'h0);
    `CHK("ignored opcode", 32'h0, rd)
    $display("test registers done");
    foreach (corner[i]) begin
      run_op(corner[i][41:40], corner[i][39:24], corner[i][23:8], corner[i][7:0]);
    end
    $display("test corners done");
    repeat (40) begin
      rv = $random(seed);
      rw = $random(seed);
      run_op(rw[1:0], rv[15:0], rv[31:16], rw[15:8]);
    end
    $display("test random done");
    xfer(1'b0, xaw_pkg::ADDR_PTREXT, 32'h0);
    `CHK("pointer extension", 32'ha5, rd)
    xfer(1'b0, xaw_pkg::ADDR_OPCNT, 32'h0);
    `CHK("op count", 32'(nops), rd)
    $display("test counters done");
    stop_test();
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("BAD watchdog exp finish got timeout");
    stop_test();
  end
endmodule

`default_nettype wire
